// [asp_pkg.sv]
// Shared constants, types and helpers of the converter packetizer.
`default_nettype none
package asp_pkg;
   // Sizes.
   localparam int NUM_IN = 8;
   localparam int RAW_W = 12;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int DEST_W = 24;
   localparam int BYTE_W = 8;
   localparam int CNT_W = 8;
   localparam int IDX_W = 3;
   localparam int WID_W = 2;
   localparam int ST_W = 3;
   localparam logic [DATA_W-RAW_W-1:0] ZERO_PAD = '0;
   // Device register map.
   localparam logic [ADDR_W-1:0] OFF_IN0 = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_GEN = 8'h20;
   localparam int ADDR_IDX_LSB = 2;
   localparam int IN_DEST_LSB = 8;
   localparam int IN_EN_BIT = 0;
   localparam int GEN_DROP_BIT = 24;
   localparam int GEN_WID_LSB = 16;
   localparam int GEN_SPP_LSB = 8;
   localparam int GEN_CAL_BIT = 1;
   localparam int GEN_EN_BIT = 0;
   // Sample width codes and reset values.
   localparam logic [WID_W-1:0] WID_8 = 2'h0;
   localparam logic [WID_W-1:0] WID_16 = 2'h1;
   localparam logic [WID_W-1:0] WID_32 = 2'h3;
   localparam logic [WID_W-1:0] WID_RST = WID_16;
   localparam logic [CNT_W-1:0] SPP_RST = 8'h01;
   localparam logic [2:0] CAL_PULSES = 3'h6;
   // Controller register map.
   localparam logic [ADDR_W-1:0] H_CADDR = 8'h00;
   localparam logic [ADDR_W-1:0] H_CDATA = 8'h04;
   localparam logic [ADDR_W-1:0] H_CMD = 8'h08;
   localparam logic [ADDR_W-1:0] H_TRIG = 8'h0C;
   localparam logic [ADDR_W-1:0] H_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] H_MASK = 8'h14;
   localparam logic [ADDR_W-1:0] H_SAMPLE = 8'h18;
   localparam logic [ADDR_W-1:0] H_SDEST = 8'h1C;
   localparam logic [ADDR_W-1:0] H_CALLEFT = 8'h20;
   localparam int CMD_WR_BIT = 0;
   localparam int CMD_RD_BIT = 1;
   localparam int ST_SMP_BIT = 0;
   localparam int ST_PKT_BIT = 1;
   localparam int ST_REF_BIT = 2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SCAN = 3'b001,
      ST_SEND = 3'b010,
      ST_ENDP = 3'b011,
      ST_CLOSE = 3'b100
   } asp_dev_state_t;

   // Index of the last byte of a sample; the reserved code is sent as 16 bits.
   function automatic logic [1:0] last_byte(input logic [WID_W-1:0] wid);
      logic [1:0] r;
      r = 2'h1;
      if (wid == WID_8)
      begin
         r = 2'h0;
      end
      else if (wid == WID_32)
      begin
         r = 2'h3;
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// [asp_link_if.sv]
// Link between the converter packetizer and its controlling party.
`timescale 1ns/1ps
`default_nettype none
interface asp_link_if;
   logic cfg_wr;
   logic cfg_rd;
   logic [asp_pkg::ADDR_W-1:0] cfg_addr;
   logic [asp_pkg::DATA_W-1:0] cfg_wdata;
   logic [asp_pkg::DATA_W-1:0] cfg_rdata;
   logic trig;
   logic pkt_valid;
   logic pkt_end;
   logic [asp_pkg::DEST_W-1:0] pkt_dest;
   logic [asp_pkg::BYTE_W-1:0] pkt_byte;

   modport dev (
      input cfg_wr, cfg_rd, cfg_addr, cfg_wdata, trig,
      output cfg_rdata, pkt_valid, pkt_end, pkt_dest, pkt_byte
   );
   modport host (
      output cfg_wr, cfg_rd, cfg_addr, cfg_wdata, trig,
      input cfg_rdata, pkt_valid, pkt_end, pkt_dest, pkt_byte
   );
endinterface
`default_nettype wire

// [asp_dev.sv]
// Converter end: control registers, calibration gate and sample packetizer.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] Input register upper field holds destination.
// [R2] Input bit zero enables that input.
// [R3] Lost sample sets flag, read clears it.
// [R4] Width field selects 8, 16, 32 bits.
// [R5] Results always left aligned in sample.
// [R6] 16-bit: low nibble zero, MSB first.
// [R7] 32-bit: low twenty bits zero, MSB first.
// [R8] Samples per packet set packet length.
// [R9] Zero count: register access closes packet.
// [R10] Calibration bit selects internal reference.
// [R11] Controller discards sample around calibration change.
// [R12] General bit zero enables the converter.
// [R13] Input registers read-only while enabled.
// [R14] Controller writes inputs only while disabled.
// [R15] Six pulses after enable calibrate silently.
// [R16] Seventh pulse onward delivers samples.
// [R17] Calibration restarts on every enable rise.
// [R18] Converter result is twelve bits.
// [R19] Each pulse samples every enabled input.
module asp_dev #(
   parameter int NUM_IN = asp_pkg::NUM_IN
) (
   // Clock, reset and clock enable.
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   // Raw converter results.
   input wire logic [NUM_IN-1:0][asp_pkg::RAW_W-1:0] adc_raw,
   input wire logic [asp_pkg::RAW_W-1:0] adc_ref_raw,
   // Converter control.
   output logic adc_on,
   output logic adc_cal_sel,
   // Link to the controlling party.
   asp_link_if.dev lnk
);
   localparam int IW = asp_pkg::IDX_W;

   if (NUM_IN < 1 || NUM_IN > 8)
   begin : g_chk
      $error("NUM_IN must lie between 1 and 8");
   end

   typedef struct packed {
      logic [NUM_IN-1:0][asp_pkg::DEST_W-1:0] dest;
      logic [NUM_IN-1:0] in_en;
      logic gen_en;
      logic cal;
      logic [asp_pkg::WID_W-1:0] width;
      logic [asp_pkg::CNT_W-1:0] spp;
      logic drop;
      logic [2:0] cal_cnt;
      logic [NUM_IN-1:0][asp_pkg::RAW_W-1:0] snap;
      logic [NUM_IN-1:0][asp_pkg::CNT_W-1:0] cnt;
      logic [NUM_IN-1:0] open;
      logic close_pend;
      asp_pkg::asp_dev_state_t st;
      logic [IW-1:0] idx;
      logic [1:0] bsel;
      logic [asp_pkg::DATA_W-1:0] word;
      logic [asp_pkg::DATA_W-1:0] rdata;
      logic pkt_valid;
      logic pkt_end;
      logic [asp_pkg::DEST_W-1:0] pkt_dest;
      logic [asp_pkg::BYTE_W-1:0] pkt_byte;
   } asp_dev_st_t;

   asp_dev_st_t q;
   asp_dev_st_t d;
   logic [NUM_IN-1:0][asp_pkg::DATA_W-1:0] ctl_word;
   logic [NUM_IN-1:0][asp_pkg::RAW_W-1:0] smp;
   logic [asp_pkg::DATA_W-1:0] gen_word;
   logic [IW-1:0] a_idx;
   logic a_in;
   logic a_gen;
   logic adv;

   for (genvar i = 0; i < NUM_IN; i++)
   begin : g_in
      assign ctl_word[i] = (asp_pkg::DATA_W'(q.dest[i]) << asp_pkg::IN_DEST_LSB)
                         | (asp_pkg::DATA_W'(q.in_en[i]) << asp_pkg::IN_EN_BIT); // [R1] [R2]
      assign smp[i] = q.cal ? adc_ref_raw : adc_raw[i]; // [R10] [R18]
   end

   assign a_idx = lnk.cfg_addr[asp_pkg::ADDR_IDX_LSB +: IW];
   assign a_in = (lnk.cfg_addr < asp_pkg::OFF_GEN) && (lnk.cfg_addr[1:0] == 2'h0)
               && (int'(a_idx) < NUM_IN);
   assign a_gen = (lnk.cfg_addr == asp_pkg::OFF_GEN);

   always_comb
   begin
      adv = 1'b0;
      d = q;
      d.rdata = '0;
      d.pkt_valid = 1'b0;
      d.pkt_end = 1'b0;
      gen_word = '0;
      gen_word[asp_pkg::GEN_DROP_BIT] = q.drop;
      gen_word[asp_pkg::GEN_WID_LSB +: asp_pkg::WID_W] = q.width;
      gen_word[asp_pkg::GEN_SPP_LSB +: asp_pkg::CNT_W] = q.spp;
      gen_word[asp_pkg::GEN_CAL_BIT] = q.cal;
      gen_word[asp_pkg::GEN_EN_BIT] = q.gen_en;
      unique case (q.st)
         asp_pkg::ST_IDLE:
         begin
            if (lnk.trig && q.gen_en)
            begin
               if (q.cal_cnt < asp_pkg::CAL_PULSES)
               begin
                  d.cal_cnt = 3'(q.cal_cnt + 3'h1); // [R15]
               end
               else
               begin
                  d.snap = smp; // [R16] [R19]
                  d.idx = '0;
                  d.st = asp_pkg::ST_SCAN;
               end
            end
            else if (q.close_pend)
            begin
               d.close_pend = 1'b0;
               d.idx = '0;
               d.st = asp_pkg::ST_CLOSE;
            end
         end
         asp_pkg::ST_SCAN:
         begin
            if (q.in_en[q.idx])
            begin
               d.word = {q.snap[q.idx], asp_pkg::ZERO_PAD}; // [R5] [R6] [R7]
               d.bsel = 2'h0;
               d.st = asp_pkg::ST_SEND;
            end
            else
            begin
               adv = 1'b1; // [R2]
            end
         end
         asp_pkg::ST_SEND:
         begin
            // Most significant byte leaves first; shorter formats stop early.
            d.pkt_valid = 1'b1;
            d.pkt_dest = q.dest[q.idx]; // [R1]
            d.pkt_byte = q.word[asp_pkg::DATA_W-1 -: asp_pkg::BYTE_W]; // [R6] [R7]
            d.word = q.word << asp_pkg::BYTE_W;
            if (q.bsel == asp_pkg::last_byte(q.width)) // [R4]
            begin
               d.cnt[q.idx] = asp_pkg::CNT_W'(q.cnt[q.idx] + 8'h01);
               d.open[q.idx] = 1'b1;
               if ((q.spp != '0) && (d.cnt[q.idx] == q.spp))
               begin
                  d.st = asp_pkg::ST_ENDP; // [R8]
               end
               else
               begin
                  adv = 1'b1;
               end
            end
            else
            begin
               d.bsel = 2'(q.bsel + 2'h1);
            end
         end
         asp_pkg::ST_ENDP, asp_pkg::ST_CLOSE:
         begin
            if ((q.st == asp_pkg::ST_ENDP) || q.open[q.idx])
            begin
               d.pkt_valid = 1'b1;
               d.pkt_end = 1'b1; // [R8] [R9]
               d.pkt_byte = '0;
               d.pkt_dest = q.dest[q.idx];
               d.cnt[q.idx] = '0;
               d.open[q.idx] = 1'b0;
            end
            adv = 1'b1;
         end
         default:
         begin
            d.st = asp_pkg::ST_IDLE;
         end
      endcase
      if (adv)
      begin
         if (q.idx == IW'(NUM_IN - 1))
         begin
            d.st = asp_pkg::ST_IDLE;
         end
         else
         begin
            d.idx = IW'(q.idx + 1);
            if (q.st != asp_pkg::ST_CLOSE)
            begin
               d.st = asp_pkg::ST_SCAN;
            end
         end
      end
      if (lnk.cfg_rd)
      begin
         if (a_in)
         begin
            d.rdata = ctl_word[a_idx];
         end
         else if (a_gen)
         begin
            d.rdata = gen_word;
            d.drop = 1'b0; // [R3]
         end
      end
      if (lnk.cfg_wr)
      begin
         // Routing cannot change under a running conversion.
         if (a_in && !q.gen_en) // [R13]
         begin
            d.dest[a_idx] = lnk.cfg_wdata[asp_pkg::IN_DEST_LSB +: asp_pkg::DEST_W]; // [R1]
            d.in_en[a_idx] = lnk.cfg_wdata[asp_pkg::IN_EN_BIT]; // [R2]
         end
         else if (a_gen)
         begin
            d.gen_en = lnk.cfg_wdata[asp_pkg::GEN_EN_BIT]; // [R12]
            d.cal = lnk.cfg_wdata[asp_pkg::GEN_CAL_BIT]; // [R10]
            d.width = lnk.cfg_wdata[asp_pkg::GEN_WID_LSB +: asp_pkg::WID_W]; // [R4]
            d.spp = lnk.cfg_wdata[asp_pkg::GEN_SPP_LSB +: asp_pkg::CNT_W]; // [R8]
            if (!q.gen_en && lnk.cfg_wdata[asp_pkg::GEN_EN_BIT])
            begin
               d.cal_cnt = '0; // [R17]
            end
         end
      end
      if ((lnk.cfg_wr || lnk.cfg_rd) && (|q.open))
      begin
         d.close_pend = 1'b1; // [R9]
      end
      // A pulse that meets a busy packetizer is lost; the set beats a clearing read.
      if (lnk.trig && q.gen_en && (q.st != asp_pkg::ST_IDLE))
      begin
         d.drop = 1'b1; // [R3]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         q <= '0;
         q.width <= asp_pkg::WID_RST; // [R4]
         q.spp <= asp_pkg::SPP_RST; // [R8]
      end
      else if (ce)
      begin
         q <= d;
      end
   end

   assign adc_on = q.gen_en; // [R12]
   assign adc_cal_sel = q.cal; // [R10]
   assign lnk.cfg_rdata = q.rdata;
   assign lnk.pkt_valid = q.pkt_valid;
   assign lnk.pkt_end = q.pkt_end;
   assign lnk.pkt_dest = q.pkt_dest;
   assign lnk.pkt_byte = q.pkt_byte;
endmodule
`default_nettype wire

// [asp_host.sv]
// Controlling end: software registers, configuration access, pulses and sample intake.
`timescale 1ns/1ps
`default_nettype none
module asp_host (
   // Clock, reset and clock enable.
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic ce,
   // Software register port.
   input wire logic [asp_pkg::ADDR_W-1:0] sw_addr,
   input wire logic [asp_pkg::DATA_W-1:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [asp_pkg::DATA_W-1:0] sw_rdata,
   // Interrupt.
   output logic irq,
   // Link to the converter.
   asp_link_if.host lnk
);
   typedef struct packed {
      logic [asp_pkg::ADDR_W-1:0] c_addr;
      logic [asp_pkg::DATA_W-1:0] c_data;
      logic cfg_wr;
      logic cfg_rd;
      logic [asp_pkg::ADDR_W-1:0] cfg_addr;
      logic [asp_pkg::DATA_W-1:0] cfg_wdata;
      logic rd_wait;
      logic trig;
      logic sh_en;
      logic sh_cal;
      logic [asp_pkg::WID_W-1:0] sh_width;
      logic [2:0] cal_left;
      logic discard;
      logic [asp_pkg::DEST_W-1:0] acc;
      logic [1:0] nb;
      logic [asp_pkg::DATA_W-1:0] sample;
      logic [asp_pkg::DEST_W-1:0] sdest;
      logic [asp_pkg::ST_W-1:0] status;
      logic [asp_pkg::ST_W-1:0] mask;
      logic [asp_pkg::DATA_W-1:0] rdata;
      logic irq;
   } asp_host_st_t;

   asp_host_st_t q;
   asp_host_st_t d;

   always_comb
   begin
      d = q;
      d.rdata = '0;
      d.cfg_wr = 1'b0;
      d.cfg_rd = 1'b0;
      d.trig = 1'b0;
      // The far end answers one cycle after the request, so capture waits a cycle.
      d.rd_wait = q.cfg_rd;
      if (q.rd_wait)
      begin
         d.c_data = lnk.cfg_rdata;
      end
      // Pulses are spaced one idle cycle apart so each is a clean single cycle.
      if ((q.cal_left != '0) && !q.trig)
      begin
         d.trig = 1'b1; // [R15]
         d.cal_left = 3'(q.cal_left - 3'h1);
      end
      if (sw_wr)
      begin
         case (sw_addr)
            asp_pkg::H_CADDR: d.c_addr = sw_wdata[asp_pkg::ADDR_W-1:0];
            asp_pkg::H_CDATA: d.c_data = sw_wdata;
            asp_pkg::H_MASK: d.mask = sw_wdata[asp_pkg::ST_W-1:0];
            asp_pkg::H_TRIG:
            begin
               if (q.cal_left == '0)
               begin
                  d.trig = 1'b1;
               end
            end
            asp_pkg::H_CMD:
            begin
               if (sw_wdata[asp_pkg::CMD_WR_BIT])
               begin
                  if ((q.c_addr < asp_pkg::OFF_GEN) && q.sh_en)
                  begin
                     d.status[asp_pkg::ST_REF_BIT] = 1'b1; // [R14]
                  end
                  else
                  begin
                     d.cfg_wr = 1'b1;
                     d.cfg_addr = q.c_addr;
                     d.cfg_wdata = q.c_data;
                     if (q.c_addr == asp_pkg::OFF_GEN)
                     begin
                        if (!q.sh_en && q.c_data[asp_pkg::GEN_EN_BIT])
                        begin
                           d.cal_left = asp_pkg::CAL_PULSES; // [R15] [R17]
                        end
                        if (q.c_data[asp_pkg::GEN_CAL_BIT] != q.sh_cal)
                        begin
                           d.discard = 1'b1; // [R11]
                        end
                        d.sh_en = q.c_data[asp_pkg::GEN_EN_BIT];
                        d.sh_cal = q.c_data[asp_pkg::GEN_CAL_BIT];
                        d.sh_width = q.c_data[asp_pkg::GEN_WID_LSB +: asp_pkg::WID_W];
                     end
                  end
               end
               else if (sw_wdata[asp_pkg::CMD_RD_BIT])
               begin
                  d.cfg_rd = 1'b1;
                  d.cfg_addr = q.c_addr;
               end
            end
            default: ;
         endcase
      end
      if (sw_rd)
      begin
         case (sw_addr)
            asp_pkg::H_CADDR: d.rdata = asp_pkg::DATA_W'(q.c_addr);
            asp_pkg::H_CDATA: d.rdata = q.c_data;
            asp_pkg::H_MASK: d.rdata = asp_pkg::DATA_W'(q.mask);
            asp_pkg::H_SAMPLE: d.rdata = q.sample;
            asp_pkg::H_SDEST: d.rdata = asp_pkg::DATA_W'(q.sdest);
            asp_pkg::H_CALLEFT: d.rdata = asp_pkg::DATA_W'(q.cal_left);
            asp_pkg::H_STATUS:
            begin
               d.rdata = asp_pkg::DATA_W'(q.status);
               d.status = '0;
            end
            default: ;
         endcase
      end
      // Intake sits after the clearing read so a new event is never lost.
      if (lnk.pkt_valid)
      begin
         if (lnk.pkt_end)
         begin
            d.status[asp_pkg::ST_PKT_BIT] = 1'b1;
         end
         else if (q.nb == asp_pkg::last_byte(q.sh_width))
         begin
            d.nb = 2'h0;
            if (q.discard)
            begin
               d.discard = 1'b0; // [R11]
            end
            else
            begin
               d.sample = {q.acc, lnk.pkt_byte} << (asp_pkg::BYTE_W * (2'h3 - q.nb));
               d.sdest = lnk.pkt_dest;
               d.status[asp_pkg::ST_SMP_BIT] = 1'b1;
            end
         end
         else
         begin
            d.acc = {q.acc[asp_pkg::DEST_W-asp_pkg::BYTE_W-1:0], lnk.pkt_byte};
            d.nb = 2'(q.nb + 2'h1);
         end
      end
      d.irq = |(d.status & d.mask);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         q <= '0;
         q.sh_width <= asp_pkg::WID_RST;
      end
      else if (ce)
      begin
         q <= d;
      end
   end

   assign sw_rdata = q.rdata;
   assign irq = q.irq;
   assign lnk.cfg_wr = q.cfg_wr;
   assign lnk.cfg_rd = q.cfg_rd;
   assign lnk.cfg_addr = q.cfg_addr;
   assign lnk.cfg_wdata = q.cfg_wdata;
   assign lnk.trig = q.trig;
endmodule
`default_nettype wire

// [asp_link_monitor.sv]
// Checker of the link between the converter end and its controller.
`timescale 1ns/1ps
`default_nettype none
module asp_link_monitor (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic nrst,
   // Configuration access.
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   // Pulses and packet tokens.
   input wire logic trig,
   input wire logic pkt_valid,
   input wire logic pkt_end,
   input wire logic [23:0] pkt_dest,
   input wire logic [7:0] pkt_byte
);
   logic en_q;
   logic [1:0] wid_q;
   logic [2:0] cal_q;
   logic [2:0] run_q;
   logic dat;
   logic [2:0] nb;
   assign dat = pkt_valid && !pkt_end;
   assign nb = (wid_q == 2'h0) ? 3'h1 : (wid_q == 2'h3) ? 3'h4 : 3'h2;
   // Pulses count from the last enable rise and saturate, so a long run cannot wrap back.
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         en_q <= 1'b0;
         wid_q <= 2'h1;
         cal_q <= 3'h0;
         run_q <= 3'h0;
      end
      else
      begin
         if (cfg_wr && cfg_addr == 8'h20)
         begin
            en_q <= cfg_wdata[0];
            wid_q <= cfg_wdata[17:16];
         end
         if (cfg_wr && cfg_addr == 8'h20 && cfg_wdata[0] && !en_q)
         begin
            cal_q <= 3'h0;
         end
         else if (trig && en_q && cal_q != 3'h7)
         begin
            cal_q <= cal_q + 3'h1;
         end
         run_q <= dat ? run_q + 3'h1 : 3'h0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   end_byte_a: assert property (pkt_valid && pkt_end |-> pkt_byte == 8'h00)
      else $error("end token carries data");
   rdata_idle_a: assert property (!$past(cfg_rd) |-> cfg_rdata == 32'h0)
      else $error("read data outside answer cycle");
   calib_quiet_a: assert property (dat |-> en_q && cal_q == 3'h7)
      else $error("sample sent before seventh pulse");
   input_wr_a: assert property (cfg_wr && cfg_addr < 8'h20 |-> !en_q)
      else $error("input register written while enabled");
   run_len_a: assert property (!dat && run_q != 3'h0 |-> run_q == nb)
      else $error("sample byte count wrong");
   nib16_a: assert property (dat && nb == 3'h2 && run_q == 3'h1 |-> pkt_byte[3:0] == 4'h0)
      else $error("16-bit padding not zero");
   low32_a: assert property (dat && nb == 3'h4 && run_q != 3'h0
      |-> pkt_byte[3:0] == 4'h0 && (run_q == 3'h1 || pkt_byte == 8'h00))
      else $error("32-bit padding not zero");
   dest_a: assert property (dat && run_q != 3'h0 |-> $stable(pkt_dest))
      else $error("destination changed within a sample");
   cover property (pkt_valid && pkt_end);
   cover property (dat && nb == 3'h4);
   cover property (cfg_wr && cfg_addr == 8'h20 && cfg_wdata[0] && !en_q);
endmodule
`default_nettype wire

// [asp_tb_top.sv]
// Testbench joining both ends, with a queue model of the packet stream.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module asp_tb_top;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic [7:0][11:0] adc_raw = '0;
   logic [11:0] adc_ref_raw = 12'h000;
   logic [7:0] sw_addr = 8'h00;
   logic [31:0] sw_wdata = 32'h0;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [31:0] sw_rdata;
   logic irq;
   logic adc_on;
   logic adc_cal_sel;
   int errors = 0;
   int total_checks = 0;
   int seed = 32'hf53b;
   logic [32:0] exp_q[$];
   logic [32:0] got_q[$];
   logic [23:0] dest[8];
   bit on[8];
   int cnt[8];
   int spp = 2;
   int wid = 1;
   bit cal = 1'b0;
   bit en = 1'b0;
   logic [31:0] d;
   logic [31:0] last_s;
   asp_link_if lnk();
   asp_dev #(.NUM_IN(8)) asp_dev_i (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .adc_raw(adc_raw),
      .adc_ref_raw(adc_ref_raw), .adc_on(adc_on), .adc_cal_sel(adc_cal_sel), .lnk(lnk));
   asp_host asp_host_i (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq),
      .lnk(lnk));
   asp_link_monitor asp_link_monitor_i (.sys_clk(sys_clk), .nrst(nrst), .cfg_wr(lnk.cfg_wr),
      .cfg_rd(lnk.cfg_rd), .cfg_addr(lnk.cfg_addr), .cfg_wdata(lnk.cfg_wdata),
      .cfg_rdata(lnk.cfg_rdata), .trig(lnk.trig), .pkt_valid(lnk.pkt_valid),
      .pkt_end(lnk.pkt_end), .pkt_dest(lnk.pkt_dest), .pkt_byte(lnk.pkt_byte));
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      if (lnk.pkt_valid === 1'b1)
         got_q.push_back({lnk.pkt_end, lnk.pkt_dest, lnk.pkt_byte});
   end
   function automatic logic [31:0] genw();
      return {14'h0, wid[1:0], spp[7:0], 6'h0, cal, en};
   endfunction
   function automatic void close_all();
      for (int i = 0; i < 8; i++)
         if (on[i] && cnt[i] != 0)
         begin
            exp_q.push_back({1'b1, dest[i], 8'h00});
            cnt[i] = 0;
         end
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_wdata <= v;
      sw_wr <= 1'b1;
      @(posedge sys_clk);
      sw_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge sys_clk);
      sw_rd <= 1'b0;
      #1 v = sw_rdata;
   endtask
   // Any link access closes open packets, so the model closes them here as well.
   task automatic dev(input logic [7:0] a, input logic [31:0] v, input bit rdop);
      wr(asp_pkg::H_CADDR, {24'h0, a});
      if (!rdop) wr(asp_pkg::H_CDATA, v);
      wr(asp_pkg::H_CMD, rdop ? 32'h2 : 32'h1);
      // Wait out the close sweep, one cycle per input, so the next pulse is not lost.
      repeat (12) @(posedge sys_clk);
      if (rdop || a == asp_pkg::OFF_GEN || !en) close_all();
      if (rdop) rd(asp_pkg::H_CDATA, d);
      else if (a != asp_pkg::OFF_GEN && !en)
      begin
         on[a >> 2] = v[0];
         dest[a >> 2] = v[31:8];
      end
   endtask
   task automatic check_pkts();
      for (int k = 0; k < 300 && got_q.size() < exp_q.size(); k++) @(posedge sys_clk);
      repeat (8) @(posedge sys_clk);
      `CHK("token count", exp_q.size(), got_q.size())
      for (int k = 0; k < exp_q.size() && k < got_q.size(); k++)
         `CHK("token", exp_q[k], got_q[k])
      exp_q.delete();
      got_q.delete();
   endtask
   task automatic enable();
      en = 1'b1;
      dev(asp_pkg::OFF_GEN, genw(), 1'b0);
      for (int k = 0; k < 40; k++)
      begin
         rd(asp_pkg::H_CALLEFT, d);
         if (d == 32'h0) break;
      end
      `CHK("pulses left", 32'h0, d)
      check_pkts();
   endtask
   task automatic round(input bit twice);
      logic [7:0][11:0] r;
      logic [11:0] rf;
      logic [31:0] s;
      int nb;
      r = {$random(seed), $random(seed), $random(seed)};
      rf = 12'($random(seed));
      nb = (wid == 0) ? 1 : (wid == 3) ? 4 : 2;
      @(posedge sys_clk);
      adc_raw <= r;
      adc_ref_raw <= rf;
      sw_addr <= asp_pkg::H_TRIG;
      sw_wr <= 1'b1;
      repeat (twice ? 2 : 1) @(posedge sys_clk);
      sw_wr <= 1'b0;
      for (int i = 0; i < 8; i++)
         if (on[i])
         begin
            s = {cal ? rf : r[i], 20'h0};
            last_s = s;
            for (int b = 0; b < nb; b++) exp_q.push_back({1'b0, dest[i], s[31 - 8 * b -: 8]});
            cnt[i]++;
            if (spp != 0 && cnt[i] == spp)
            begin
               exp_q.push_back({1'b1, dest[i], 8'h00});
               cnt[i] = 0;
            end
         end
      check_pkts();
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #100000;
      errors++;
      summarize();
   end
   initial
   begin
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      dev(asp_pkg::OFF_GEN, 32'h0, 1'b1);
      `CHK("general reset", 32'h0001_0100, d)
      dev(8'h0C, 32'h0, 1'b1);
      `CHK("input reset", 32'h0, d)
      for (int i = 0; i < 8; i += 3) dev(8'(4 * i), {24'($random(seed)), 8'h01}, 1'b0);
      dev(8'h0C, 32'h0, 1'b1);
      `CHK("input route", {dest[3], 8'h01}, d)
      $display("test setup done");
      enable();
      dev(8'h0C, 32'h0, 1'b0);
      rd(asp_pkg::H_STATUS, d);
      `CHK("refused write", 1'b1, d[2])
      dev(8'h0C, 32'h0, 1'b1);
      `CHK("input locked", {dest[3], 8'h01}, d)
      $display("test lock done");
      for (int w = 0; w < 4; w++)
      begin
         wid = w;
         dev(asp_pkg::OFF_GEN, genw(), 1'b0);
         round(1'b0);
         round(1'b0);
      end
      cal = 1'b1;
      dev(asp_pkg::OFF_GEN, genw(), 1'b0);
      round(1'b0);
      cal = 1'b0;
      dev(asp_pkg::OFF_GEN, genw(), 1'b0);
      round(1'b0);
      $display("test formats done");
      `CHK("irq masked", 1'b0, irq)
      wr(asp_pkg::H_MASK, 32'h2);
      repeat (2) @(posedge sys_clk);
      #1 `CHK("irq raised", 1'b1, irq)
      rd(asp_pkg::H_STATUS, d);
      `CHK("packet end status", 1'b1, d[1])
      repeat (2) @(posedge sys_clk);
      #1 `CHK("irq cleared", 1'b0, irq)
      $display("test irq done");
      round(1'b1);
      dev(asp_pkg::OFF_GEN, 32'h0, 1'b1);
      `CHK("drop set", 32'h0100_0000 | genw(), d)
      dev(asp_pkg::OFF_GEN, 32'h0, 1'b1);
      `CHK("drop cleared", genw(), d)
      check_pkts();
      $display("test drop done");
      spp = 0;
      dev(asp_pkg::OFF_GEN, genw(), 1'b0);
      round(1'b0);
      round(1'b0);
      dev(asp_pkg::OFF_GEN, 32'h0, 1'b1);
      check_pkts();
      $display("test open packet done");
      spp = 1;
      en = 1'b0;
      dev(asp_pkg::OFF_GEN, genw(), 1'b0);
      enable();
      round(1'b0);
      rd(asp_pkg::H_SAMPLE, d);
      `CHK("stored sample", last_s, d)
      $display("test re-enable done");
      summarize();
   end
endmodule
`default_nettype wire
